// [rtl/wmcl_pkg.sv]
// Constants, register map and state codes of the control-line block.
// Assumes a single 40 MHz clock and APB byte addresses, one word each.
package wmcl_pkg;
   // Clock and power-up toggle window
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned FR_WINDOW_S   = 5;
   localparam int unsigned FR_WINDOW_CYC = FR_WINDOW_S * CLK_HZ;
   localparam int unsigned FR_TOGGLES    = 3;
   localparam int unsigned FR_CNT_W      = 28;

   // Buffer shapes
   localparam int unsigned BYTE_W    = 8;
   localparam int unsigned RXF_DEPTH = 8;
   localparam int unsigned MSG_DEPTH = 256;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STAT_OFF = 12'h004;
   localparam logic [11:0] MSG_OFF  = 12'h008;
   localparam logic [11:0] RXD_OFF  = 12'h00c;

   // Control fields and reset value
   localparam int unsigned CTRL_BAUD_BIT = 0;
   localparam int unsigned CTRL_DORM_BIT = 1;
   localparam logic        CTRL_BAUD_RST = 1'b0;

   // Status fields
   localparam int unsigned STAT_LINK_BIT  = 3;
   localparam int unsigned STAT_FR_BIT    = 4;
   localparam int unsigned STAT_FULL_BIT  = 5;
   localparam int unsigned STAT_MCNT_LSB  = 8;
   localparam int unsigned RXD_VALID_BIT  = 8;

   // Banners, first byte in the top lane
   localparam int unsigned BANNER_LEN = 5;
   localparam logic [39:0] BAN_CMD    = 40'h434d440d0a;
   localparam logic [39:0] BAN_END    = 40'h454e440d0a;

   // Control input positions
   localparam int unsigned IN_SW = 0;
   localparam int unsigned IN_MS = 1;
   localparam int unsigned IN_DW = 2;

   typedef enum logic [2:0] {
      ST_SLEEP   = 3'b000,
      ST_CMD     = 3'b001,
      ST_DATA    = 3'b011,
      ST_ENDING  = 3'b010,
      ST_DORMANT = 3'b100
   } wmcl_state_t;
endpackage

// [rtl/wmcl_top.sv]
// Control-line state logic: mode machine, banners, held-back messages.
// Assumes UART framing outside; bytes arrive and leave by valid/ready.
//
// Behaviour
// - Sleep-wake high wakes into Active mode
// - On wake send command banner
// - Sleep-wake low: end banner, then Deep Sleep
// - Deep Sleep ignores UART unless 2400 baud
// - Data-event indicator low in Deep Sleep
// - Mode-select high: stream UART bytes to peer
// - Mode-select low: back to command, banner
// - Dormant-wake high leaves Dormant mode
// - Three toggles in five seconds: factory reset (code fires on the fourth dormant-wake rise)
// - Sleep-wake high makes reset full, else partial
// - Link-up indicator follows peer connection
// - Data mode: pending message raises data-event
// - Command mode drains messages, then indicator low
// - Message buffer holds 256 bytes
// - Activity indicator high while Active
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module wmcl_fifo #(
   parameter int  W  = 8,
   parameter int  D  = 8,
   localparam int AW = $clog2(D)
) (
   // Clock
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // Fill side
   input  wire logic          in_valid,
   input  wire logic [W-1:0]  in_data,
   output logic               in_ready,
   // Drain side
   output logic               out_valid,
   output logic [W-1:0]       out_data,
   input  wire logic          out_ready,
   output logic [AW:0]        count
);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } wmcl_fifo_state_t;

   wmcl_fifo_state_t r;
   wmcl_fifo_state_t n;
   logic             push;
   logic             pop;

   assign in_ready  = (r.cnt != (AW+1)'(D));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rp];
   assign count     = r.cnt;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Depth must be a power of two so pointers wrap by themselves
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp        = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      if (push & ~pop) begin
         n.cnt = r.cnt + 1'b1;
      end else if (pop & ~push) begin
         n.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
endmodule

module wmcl_top #(
   parameter int unsigned FR_WIN = wmcl_pkg::FR_WINDOW_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Control pins from the host
   input  wire logic        sleep_wake_input,
   input  wire logic        mode_select_input,
   input  wire logic        dormant_wake_input,
   // Indicator pins
   output logic             link_up_indicator,
   output logic             data_event_indicator,
   output logic             activity_indicator,
   // UART receive bytes
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   // UART transmit bytes
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // Peer stream and link state from the radio side
   output logic             peer_valid,
   output logic [7:0]       peer_data,
   input  wire logic        peer_ready,
   input  wire logic        link_connected,
   // Factory reset request
   output logic             factory_reset,
   output logic             factory_reset_full
);
   typedef struct packed {
      logic [2:0]                     s1;
      logic [2:0]                     s2;
      logic [2:0]                     s3;
      logic [2:0]                     filt;
      wmcl_pkg::wmcl_state_t          st;
      logic                           baud2400;
      logic                           dorm_req;
      logic [2:0]                     ban_idx;
      logic                           ban_busy;
      logic                           ban_end;
      logic                           tx_valid;
      logic [7:0]                     tx_data;
      logic                           link;
      logic                           dei;
      logic                           act;
      logic [wmcl_pkg::FR_CNT_W-1:0]  fr_cnt;
      logic                           fr_open;
      logic                           fr_high;
      logic [1:0]                     fr_tog;
      logic                           fr_done;
      logic                           fr_pulse;
      logic                           fr_full;
      logic [31:0]                    prdata;
      logic                           pslverr;
   } wmcl_top_state_t;

   wmcl_top_state_t r;
   wmcl_top_state_t n;

   logic       setup;
   logic       access;
   logic       rx_accept;
   logic       rxf_in_ready;
   logic       rxf_valid;
   logic [7:0] rxf_data;
   logic       rxf_pop;
   logic       msg_push;
   logic       msg_in_ready;
   logic       msg_valid;
   logic [7:0] msg_data;
   logic       msg_pop;
   logic [8:0] msg_cnt;
   logic [3:0] rxf_cnt;
   logic       tx_free;
   logic [39:0] ban_word;
   logic [2:0] rise;
   logic       awake;

   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign prdata  = r.prdata;
   assign pslverr = r.pslverr;

   assign awake = (r.st == wmcl_pkg::ST_CMD) | (r.st == wmcl_pkg::ST_DATA)
                | (r.st == wmcl_pkg::ST_ENDING);
   // Deep Sleep drops bytes unless the slow rate is set
   assign rx_accept = awake
                    | ((r.st == wmcl_pkg::ST_SLEEP) & r.baud2400);
   assign rx_ready  = rx_accept ? rxf_in_ready : 1'b1;
   // Data mode streams every received byte to the peer
   assign peer_valid = (r.st == wmcl_pkg::ST_DATA) & rxf_valid;
   assign peer_data  = rxf_data;
   assign rxf_pop = (r.st == wmcl_pkg::ST_DATA) ? peer_ready
                  : (access & ~pwrite & (paddr == wmcl_pkg::RXD_OFF));
   assign msg_push = access & pwrite & (paddr == wmcl_pkg::MSG_OFF)
                   & ~r.pslverr;
   assign tx_free  = ~r.tx_valid | tx_ready;
   // Messages wait through data mode, drain in command mode
   assign msg_pop  = tx_free & ~r.ban_busy & msg_valid
                   & (r.st == wmcl_pkg::ST_CMD);
   assign ban_word = r.ban_end ? wmcl_pkg::BAN_END : wmcl_pkg::BAN_CMD;

   assign tx_valid             = r.tx_valid;
   assign tx_data              = r.tx_data;
   assign link_up_indicator    = r.link;
   assign data_event_indicator = r.dei;
   assign activity_indicator   = r.act;
   assign factory_reset        = r.fr_pulse;
   assign factory_reset_full   = r.fr_full;

   wmcl_fifo #(.W(wmcl_pkg::BYTE_W), .D(wmcl_pkg::RXF_DEPTH)) u_rxf (
      .clk       (pclk),
      .rst_n     (presetn),
      .ce        (clk_en),
      .in_valid  (rx_valid & rx_accept),
      .in_data   (rx_data),
      .in_ready  (rxf_in_ready),
      .out_valid (rxf_valid),
      .out_data  (rxf_data),
      .out_ready (rxf_pop),
      .count     (rxf_cnt)
   );

   // Message store sized for the full held-back backlog
   wmcl_fifo #(.W(wmcl_pkg::BYTE_W), .D(wmcl_pkg::MSG_DEPTH)) u_msg (
      .clk       (pclk),
      .rst_n     (presetn),
      .ce        (clk_en),
      .in_valid  (msg_push),
      .in_data   (pwdata[7:0]),
      .in_ready  (msg_in_ready),
      .out_valid (msg_valid),
      .out_data  (msg_data),
      .out_ready (msg_pop),
      .count     (msg_cnt)
   );

   always_comb begin
      n = r;
      // Three stages; a change counts once stages two and three agree
      n.s1 = {dormant_wake_input, mode_select_input, sleep_wake_input};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.filt = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.filt);
      rise = n.filt & ~r.filt;

      // Mode machine; a banner in flight blocks further transitions
      case (r.st)
         wmcl_pkg::ST_SLEEP: begin
            if (r.filt[wmcl_pkg::IN_SW]) begin
               n.st       = wmcl_pkg::ST_CMD;
               n.ban_busy = 1'b1;
               n.ban_end  = 1'b0;
               n.ban_idx  = '0;
            end
         end
         wmcl_pkg::ST_CMD: begin
            if (!r.ban_busy) begin
               if (!r.filt[wmcl_pkg::IN_SW]) begin
                  n.st       = wmcl_pkg::ST_ENDING;
                  n.ban_busy = 1'b1;
                  n.ban_end  = 1'b1;
                  n.ban_idx  = '0;
               end else if (r.dorm_req) begin
                  n.st       = wmcl_pkg::ST_DORMANT;
                  n.dorm_req = 1'b0;
               end else if (r.filt[wmcl_pkg::IN_MS]) begin
                  n.st       = wmcl_pkg::ST_DATA;
               end
            end
         end
         wmcl_pkg::ST_DATA: begin
            if (!r.filt[wmcl_pkg::IN_SW]) begin
               n.st       = wmcl_pkg::ST_ENDING;
               n.ban_busy = 1'b1;
               n.ban_end  = 1'b1;
               n.ban_idx  = '0;
            end else if (!r.filt[wmcl_pkg::IN_MS]) begin
               n.st       = wmcl_pkg::ST_CMD;
               n.ban_busy = 1'b1;
               n.ban_end  = 1'b0;
               n.ban_idx  = '0;
            end
         end
         wmcl_pkg::ST_ENDING: begin
            // Sleep only once the last banner byte left the port
            if (!r.ban_busy && !r.tx_valid) begin
               n.st = wmcl_pkg::ST_SLEEP;
            end
         end
         wmcl_pkg::ST_DORMANT: begin
            if (r.filt[wmcl_pkg::IN_DW]) begin
               n.st = wmcl_pkg::ST_SLEEP;
            end
         end
         default: begin
            n.st = wmcl_pkg::ST_SLEEP;
         end
      endcase

      // Transmit slot: banner first, then held-back messages
      if (tx_free) begin
         n.tx_valid = 1'b0;
         if (r.ban_busy) begin
            n.tx_valid = 1'b1;
            n.tx_data  = ban_word[39 - 8*r.ban_idx -: 8];
            n.ban_idx  = r.ban_idx + 1'b1;
            if (r.ban_idx == 3'(wmcl_pkg::BANNER_LEN - 1)) begin
               n.ban_busy = 1'b0;
            end
         end else if (msg_pop) begin
            n.tx_valid = 1'b1;
            n.tx_data  = msg_data;
         end
      end

      // Indicators, registered: link from the input pin, activity and data-event from the next state
      n.link = link_connected;
      n.act  = (n.st == wmcl_pkg::ST_CMD) | (n.st == wmcl_pkg::ST_DATA)
             | (n.st == wmcl_pkg::ST_ENDING);
      // Pending count after this cycle's push and pop
      n.dei  = (n.st != wmcl_pkg::ST_SLEEP)
             & (n.st != wmcl_pkg::ST_DORMANT)
             & ((msg_cnt != 9'h000 & ~(msg_cnt == 9'h001 & msg_pop))
                | msg_push);

      // Power-up toggle counter; only one reset per power cycle
      n.fr_pulse = 1'b0;
      if (r.fr_open) begin
         n.fr_cnt = r.fr_cnt + 1'b1;
         if (r.fr_cnt == wmcl_pkg::FR_CNT_W'(FR_WIN - 1)) begin
            n.fr_open = 1'b0;
         end
         if (r.filt[wmcl_pkg::IN_DW]) begin
            n.fr_high = 1'b1;
         end
         if (rise[wmcl_pkg::IN_DW] && r.fr_high && !r.fr_done) begin
            n.fr_tog = r.fr_tog + 1'b1;
            if (r.fr_tog == 2'(wmcl_pkg::FR_TOGGLES - 1)) begin
               n.fr_done  = 1'b1;
               n.fr_pulse = 1'b1;
               n.fr_full  = r.filt[wmcl_pkg::IN_SW];
            end
         end
      end

      // APB: decode in setup, act in access, always zero wait
      if (setup) begin
         n.prdata  = 32'h0000_0000;
         n.pslverr = 1'b0;
         case (paddr)
            wmcl_pkg::CTRL_OFF: begin
               n.prdata[wmcl_pkg::CTRL_BAUD_BIT] = r.baud2400;
            end
            wmcl_pkg::STAT_OFF: begin
               n.prdata[2:0] = r.st;
               n.prdata[wmcl_pkg::STAT_LINK_BIT] = r.link;
               n.prdata[wmcl_pkg::STAT_FR_BIT]   = r.fr_done;
               n.prdata[wmcl_pkg::STAT_FULL_BIT] = r.fr_full;
               n.prdata[wmcl_pkg::STAT_MCNT_LSB +: 9] = msg_cnt;
            end
            wmcl_pkg::MSG_OFF: begin
               n.pslverr = pwrite & ~msg_in_ready;
            end
            wmcl_pkg::RXD_OFF: begin
               n.prdata[7:0] = rxf_data;
               n.prdata[wmcl_pkg::RXD_VALID_BIT] =
                  rxf_valid & (r.st != wmcl_pkg::ST_DATA);
            end
            default: begin
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (access & pwrite & (paddr == wmcl_pkg::CTRL_OFF)) begin
         n.baud2400 = pwdata[wmcl_pkg::CTRL_BAUD_BIT];
         if (pwdata[wmcl_pkg::CTRL_DORM_BIT]) begin
            n.dorm_req = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.st       <= wmcl_pkg::ST_SLEEP;
         r.baud2400 <= wmcl_pkg::CTRL_BAUD_RST;
         r.fr_open  <= 1'b1;
      end else if (clk_en) begin
         r <= n;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sleep_dei_low_a: assert property (
      r.st == wmcl_pkg::ST_SLEEP |-> !data_event_indicator)
      else $error("data event high in deep sleep");
   wake_banner_a: assert property (
      clk_en && r.st == wmcl_pkg::ST_SLEEP && r.filt[0] |=>
      ##[0:20] tx_valid && tx_data == wmcl_pkg::BAN_CMD[39:32])
      else $error("no command banner after wake");
   wake_active_a: assert property (
      clk_en && r.st == wmcl_pkg::ST_SLEEP && r.filt[0] |=>
      activity_indicator && r.st == wmcl_pkg::ST_CMD)
      else $error("wake did not enter active mode");
   end_sleep_a: assert property (
      $rose(r.st == wmcl_pkg::ST_ENDING) |->
      r.ban_end && r.ban_busy ##[1:300] r.st == wmcl_pkg::ST_SLEEP)
      else $error("end banner not followed by sleep");
   sleep_rx_drop_a: assert property (
      r.st == wmcl_pkg::ST_SLEEP && !r.baud2400 |->
      rx_ready && !(rx_valid && rx_accept))
      else $error("uart taken in deep sleep");
   data_forward_a: assert property (
      r.st == wmcl_pkg::ST_DATA && rxf_valid |-> peer_valid &&
      peer_data == rxf_data)
      else $error("data mode byte not offered");
   data_exit_a: assert property (
      clk_en && r.st == wmcl_pkg::ST_DATA && r.filt[0] && !r.filt[1] |=>
      r.st == wmcl_pkg::ST_CMD && r.ban_busy && !r.ban_end)
      else $error("data exit without banner");
   dormant_wake_a: assert property (
      clk_en && r.st == wmcl_pkg::ST_DORMANT && r.filt[2] |=>
      r.st == wmcl_pkg::ST_SLEEP)
      else $error("dormant not left");
   fr_window_a: assert property (
      factory_reset |-> $past(r.fr_open) && r.fr_done &&
      r.fr_tog == 2'(wmcl_pkg::FR_TOGGLES))
      else $error("factory reset outside window");
   fr_kind_a: assert property (
      $rose(factory_reset) |-> factory_reset_full == $past(r.filt[0]))
      else $error("factory reset kind wrong");
   link_follow_a: assert property (
      clk_en |=> link_up_indicator == $past(link_connected))
      else $error("link indicator lags");
   data_event_a: assert property (
      clk_en && r.st == wmcl_pkg::ST_DATA && msg_cnt != 9'h000 |=>
      data_event_indicator)
      else $error("pending message not flagged");
   drain_low_a: assert property (
      clk_en && msg_cnt == 9'h000 && !msg_push |=> !data_event_indicator)
      else $error("indicator high with empty store");
   msg_bound_a: assert property (
      msg_cnt <= 9'(wmcl_pkg::MSG_DEPTH) &&
      (msg_cnt == 9'h100) == !msg_in_ready)
      else $error("message store bound broken");
   sync_agree_a: assert property (
      clk_en && r.filt != n.filt |-> r.s2 == r.s3)
      else $error("input changed without agreement");
   rx_full_stall_a: assert property (
      rx_accept && rxf_cnt == 4'(wmcl_pkg::RXF_DEPTH) |-> !rx_ready)
      else $error("uart byte offered to full buffer");

   wake_to_data_c: cover property (
      r.st == wmcl_pkg::ST_CMD ##[1:50] r.st == wmcl_pkg::ST_DATA);
   factory_reset_c: cover property (factory_reset);
   drain_c: cover property (
      data_event_indicator && r.st == wmcl_pkg::ST_CMD
      ##[1:100] !data_event_indicator);
   slow_rx_c: cover property (
      r.st == wmcl_pkg::ST_SLEEP && rx_valid && rx_accept);
endmodule

// [verification/wmcl_host.sv]
// Host UART model: takes device bytes, offers queued host bytes.
// Assumes the block's byte valid/ready ports on the one clock pclk.
`timescale 1ns/1ps

module wmcl_host (
   // Clock, reset, stall request
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       slow,
   // Device to host
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   // Host to device
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   input  wire logic       rx_ready
);
   logic [7:0] got[$];
   logic [7:0] send[$];

   // Stalls come from the bench, so slow answers happen too
   assign tx_ready = presetn & ~slow;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   always @(posedge pclk) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      if (rx_valid && rx_ready) begin
         rx_valid <= 1'b0;
         // Released line must not keep showing the old byte
         rx_data  <= ~rx_data;
      end else if (!rx_valid && send.size() > 0) begin
         rx_valid <= 1'b1;
         rx_data  <= send.pop_front();
      end
   end
endmodule

// [verification/wireless_module_control_lines_test.sv]
// Bench of the control-line block: pins, APB, UART and peer stream.
// Assumes wmcl_pkg, wmcl_top and wmcl_host are compiled before it.
`timescale 1ns/1ps

module wireless_module_control_lines_test;
   localparam int unsigned FR_WIN = 2000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, rs;
   logic        sw, ms, dw, lnk, link_up, dev, act, frst, frfull, slow, ce;
   logic        rxv, rxr, txv, txr, pv, pr, err;
   logic [7:0]  rxd, txd, pd;
   logic [7:0]  exp_q[$], peer_q[$], msg_q[$];
   int          bad_count, cmp_count, cyc, fr_n;

   wmcl_top #(.FR_WIN(FR_WIN)) uut (
      .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_wake_input(sw), .mode_select_input(ms),
      .dormant_wake_input(dw), .link_up_indicator(link_up),
      .data_event_indicator(dev), .activity_indicator(act),
      .rx_valid(rxv), .rx_data(rxd), .rx_ready(rxr), .tx_valid(txv),
      .tx_data(txd), .tx_ready(txr), .peer_valid(pv), .peer_data(pd),
      .peer_ready(pr), .link_connected(lnk), .factory_reset(frst),
      .factory_reset_full(frfull));
   wmcl_host host (.pclk(pclk), .presetn(presetn), .slow(slow),
      .tx_valid(txv), .tx_data(txd), .tx_ready(txr), .rx_valid(rxv),
      .rx_data(rxd), .rx_ready(rxr));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Banner bytes leave top lane first
   function automatic void add_ban(input logic [39:0] b);
      for (int i = 0; i < wmcl_pkg::BANNER_LEN; i++)
         exp_q.push_back(b[39-8*i -: 8]);
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_bytes(input bit peer);
      logic [7:0] g[$];
      for (int i = 0; i < 4000; i++) begin
         if (peer)
            g = peer_q;
         else
            g = host.got;
         if (g.size() >= exp_q.size())
            break;
         @(posedge pclk);
      end
      chk(g.size(), exp_q.size());
      foreach (exp_q[k])
         if (k < g.size())
            chk(g[k], exp_q[k]);
      peer_q.delete();
      host.got.delete();
      exp_q.delete();
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Random stalls on both far sides, pulse count, hang guard
   always @(posedge pclk) begin
      cyc  <= cyc + 1;
      rs   <= xs(rs);
      slow <= rs[0] & rs[3];
      pr   <= rs[5] | rs[9];
      if (pv && pr)
         peer_q.push_back(pd);
      if (frst)
         fr_n <= fr_n + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, sw, ms, dw, lnk, slow, pr} = '0;
      ce = 1'b1;
      paddr = '0;
      pwdata = '0;
      seed = 32'h32fc;
      rs = 32'h32fc;
      {bad_count, cmp_count, cyc, fr_n} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({act, dev, link_up, frst, frfull, txv, pready}, 7'h01);
      sw <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(act, 1'b1);
      // Fourth toggle cycle is the one that must fire, not the third
      for (int t = 1; t <= 4; t++) begin
         dw <= 1'b1;
         repeat (8) @(posedge pclk);
         dw <= 1'b0;
         repeat (8) @(posedge pclk);
         if (t == 3)
            chk(fr_n, 0);
      end
      chk(fr_n, 1);
      chk(frfull, 1'b1);
      add_ban(wmcl_pkg::BAN_CMD);
      chk_bytes(1'b0);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[5:0], 6'h31);
      // One-sample glitch must not switch mode
      ms <= 1'b1;
      @(posedge pclk);
      ms <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[2:0], wmcl_pkg::ST_CMD);
      // Clock enable low freezes the indicator
      ce  <= 1'b0;
      lnk <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(link_up, 1'b0);
      ce  <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(link_up, 1'b1);
      lnk <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(link_up, 1'b0);
      apb(1'b0, 12'h010, '0);
      chk(err, 1'b1);
      apb(1'b0, wmcl_pkg::CTRL_OFF, '0);
      chk(rd[1:0], 2'b00);
      ms <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[2:0], wmcl_pkg::ST_DATA);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         host.send.push_back(seed[7:0]);
         exp_q.push_back(seed[7:0]);
      end
      chk_bytes(1'b1);
      for (int i = 0; i <= wmcl_pkg::MSG_DEPTH; i++) begin
         seed = xs(seed);
         apb(1'b1, wmcl_pkg::MSG_OFF, {24'h0, seed[7:0]});
         if (i < wmcl_pkg::MSG_DEPTH)
            msg_q.push_back(seed[7:0]);
         if (i == wmcl_pkg::MSG_DEPTH - 1)
            chk(err, 1'b0);
      end
      chk(err, 1'b1);
      chk(dev, 1'b1);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[16:8], 9'h100);
      ms <= 1'b0;
      add_ban(wmcl_pkg::BAN_CMD);
      exp_q = {exp_q, msg_q};
      chk_bytes(1'b0);
      repeat (3) @(posedge pclk);
      chk(dev, 1'b0);
      apb(1'b1, wmcl_pkg::CTRL_OFF, 32'h2);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[2:0], wmcl_pkg::ST_DORMANT);
      chk(act, 1'b0);
      dw <= 1'b1;
      add_ban(wmcl_pkg::BAN_CMD);
      chk_bytes(1'b0);
      dw <= 1'b0;
      sw <= 1'b0;
      add_ban(wmcl_pkg::BAN_END);
      chk_bytes(1'b0);
      apb(1'b1, wmcl_pkg::MSG_OFF, 32'h5a);
      repeat (4) @(posedge pclk);
      chk({act, dev}, 2'b00);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[2:0], wmcl_pkg::ST_SLEEP);
      host.send.push_back(8'ha5);
      repeat (6) @(posedge pclk);
      apb(1'b0, wmcl_pkg::RXD_OFF, '0);
      chk(rd[8], 1'b0);
      apb(1'b1, wmcl_pkg::CTRL_OFF, 32'h1);
      apb(1'b0, wmcl_pkg::CTRL_OFF, '0);
      chk(rd[1:0], 2'b01);
      seed = xs(seed);
      host.send.push_back(seed[7:0]);
      repeat (6) @(posedge pclk);
      apb(1'b0, wmcl_pkg::RXD_OFF, '0);
      chk(rd[8:0], {1'b1, seed[7:0]});
      // Second power-up, sleep-wake low: partial factory reset
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({act, dev, frst, frfull, txv}, 5'h00);
      for (int t = 1; t <= 4; t++) begin
         dw <= 1'b1;
         repeat (8) @(posedge pclk);
         dw <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      chk(fr_n, 2);
      chk(frfull, 1'b0);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[5:0], 6'h10);
      // Leave data mode by sleep-wake low
      sw <= 1'b1;
      ms <= 1'b1;
      add_ban(wmcl_pkg::BAN_CMD);
      chk_bytes(1'b0);
      apb(1'b0, wmcl_pkg::STAT_OFF, '0);
      chk(rd[2:0], wmcl_pkg::ST_DATA);
      sw <= 1'b0;
      add_ban(wmcl_pkg::BAN_END);
      chk_bytes(1'b0);
      stop_test();
   end
endmodule
